// File: hw/tlb_entry_ram.sv
// Entry storage: one set read at a time, all ways at once, one way written.
// Assumes the caller never reads and writes the same set in one cycle.
`timescale 1ns/1ps
`default_nettype none
module tlb_entry_ram #(
   parameter int SETS = 8,
   parameter int WAYS = 4,
   parameter int WIDTH = 43
) (
   input wire logic ref_clk,
   input wire logic rd_en,
   input wire logic [$clog2(SETS)-1:0] rd_set,
   input wire logic wr_en,
   input wire logic [$clog2(SETS)-1:0] wr_set,
   input wire logic [$clog2(WAYS)-1:0] wr_way,
   input wire logic [WIDTH-1:0] wr_data,
   output logic [WAYS*WIDTH-1:0] rd_data
);
   // No reset: valid bits live outside, so stale contents never hit
   logic [WIDTH-1:0] mem_q [SETS*WAYS];

   always_ff @(posedge ref_clk)
   begin
      if (wr_en)
      begin
         mem_q[{wr_set, wr_way}] <= wr_data;
      end
      if (rd_en)
      begin
         for (int w = 0; w < WAYS; w++)
         begin
            rd_data[w*WIDTH +: WIDTH] <= mem_q[rd_set*WAYS + w];
         end
      end
   end
endmodule : tlb_entry_ram
`default_nettype wire

// File: hw/tlb_test_pkg.sv
// Constants, field layout and state codes for the translation buffer test port.
// Assumes one core clock; the core decodes the move instructions for us.
package tlb_test_pkg;
   // ****************************************
   // Array shape
   // ****************************************
   localparam int NUM_ENTRIES = 32;
   localparam int NUM_WAYS = 4;
   localparam int WAY_BITS = 2;
   localparam int TAG_BITS = 24;
   localparam int DATA_BITS = 20;
   localparam int LRU_BITS = 3;
   localparam int ATTR_BITS = 3;
   // ****************************************
   // Field positions, both test registers
   // ****************************************
   localparam int PAGE_LSB = 12;
   localparam int CMD_BIT = 0;
   localparam int VALID_BIT = 11;
   localparam int DIRTY_BIT = 10;
   localparam int USER_BIT = 8;
   localparam int RW_BIT = 6;
   localparam int LRU_LSB = 7;
   localparam int HIT_BIT = 4;
   localparam int WAY_LSB = 2;
   // ****************************************
   // Writable bits and reset values
   // ****************************************
   localparam logic [31:0] DATA_WMASK = 32'hffff_f39c;
   localparam logic [31:0] CTRL_WMASK = 32'hffff_ffe1;
   localparam logic [31:0] DATA_RESET = 32'h0000_0000;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
   // ****************************************
   // Register select and sequencer states
   // ****************************************
   localparam logic SEL_DATA = 1'b0;
   localparam logic SEL_CTRL = 1'b1;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_FETCH = 2'b01,
      ST_EXEC = 2'b10
   } op_state_t;
endpackage : tlb_test_pkg

// File: hw/tlb_test_register_access.sv
// Test access path into the translation buffer: two test registers and the
// write and lookup sequencer behind them.
// Assumes the core decodes register moves and presents them as strobes.
`timescale 1ns/1ps
`default_nettype none
module tlb_test_register_access #(
   parameter int NUM_ENTRIES = tlb_test_pkg::NUM_ENTRIES,
   parameter int NUM_WAYS = tlb_test_pkg::NUM_WAYS
) (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic mov_wr,
   input wire logic mov_rd,
   input wire logic mov_sel,
   input wire logic [31:0] mov_wdata,
   input wire logic [1:0] cpl,
   input wire logic real_mode,
   output logic [31:0] mov_rdata,
   output logic mov_fault,
   output logic busy
);
   // ****************************************
   // Shape and checks
   // ****************************************
   localparam int SETS = NUM_ENTRIES / NUM_WAYS;
   localparam int SET_BITS = $clog2(SETS);
   localparam int ENTRY_W = tlb_test_pkg::TAG_BITS - 1 + tlb_test_pkg::DATA_BITS;
   localparam int PAGE_LO = tlb_test_pkg::PAGE_LSB;

   // Tree LRU is built for exactly four ways
   if (NUM_WAYS != 4 || SETS < 2 || (SETS & (SETS - 1)) != 0)
   begin : g_bad_shape
      $error("tlb test: unsupported entry count or way count");
   end

   typedef struct packed {
      tlb_test_pkg::op_state_t st;
      logic [31:0] data;
      logic [31:0] ctrl;
      logic [31:0] rdata;
      logic [NUM_ENTRIES-1:0] valid;
      logic [SETS*3-1:0] lru;
   } state_t;

   state_t r_q;
   state_t r_d;

   // ****************************************
   // Helpers
   // ****************************************
   // A pair of 10 wants the bit set, 01 clear; 00 and 11 do not care
   function automatic logic attr_ok(input logic [1:0] pair, input logic bit_v);
      attr_ok = (pair == 2'b10) ? bit_v : ((pair == 2'b01) ? !bit_v : 1'b1);
   endfunction : attr_ok

   function automatic logic [1:0] plru_victim(input logic [2:0] l);
      plru_victim = l[0] ? {1'b1, l[2]} : {1'b0, l[1]};
   endfunction : plru_victim

   // Point the tree away from the way just used
   function automatic logic [2:0] plru_touch(input logic [2:0] l, input logic [1:0] w);
      logic [2:0] t;
      t = l;
      t[0] = !w[1];
      if (w[1])
      begin
         t[2] = !w[0];
      end
      else
      begin
         t[1] = !w[0];
      end
      plru_touch = t;
   endfunction : plru_touch

   // ****************************************
   // Entry memory
   // ****************************************
   logic ram_rd;
   logic ram_we;
   logic [SET_BITS-1:0] set_idx;
   logic [1:0] wr_way;
   logic [ENTRY_W-1:0] wr_entry;
   logic [NUM_WAYS*ENTRY_W-1:0] rd_entries;

   tlb_entry_ram #(
      .SETS(SETS),
      .WAYS(NUM_WAYS),
      .WIDTH(ENTRY_W)
   ) u_ram (
      .ref_clk(ref_clk),
      .rd_en(ram_rd),
      .rd_set(set_idx),
      .wr_en(ram_we),
      .wr_set(set_idx),
      .wr_way(wr_way),
      .wr_data(wr_entry),
      .rd_data(rd_entries)
   );

   // ****************************************
   // Sequencer and test registers
   // ****************************************
   logic priv_ok;
   logic take;
   logic is_lookup;
   logic hit;
   logic [1:0] hit_way;
   logic [2:0] lru_cur;
   logic [ENTRY_W-1:0] hit_entry;
   logic [ENTRY_W-1:0] e;
   logic [1:0] free_way;
   logic any_free;
   logic [SET_BITS+1:0] vidx;
   logic [SET_BITS+1:0] wr_idx;

   always_comb
   begin
      r_d = r_q;
      ram_rd = 1'b0;
      ram_we = 1'b0;
      wr_way = 2'b00;
      hit = 1'b0;
      hit_way = 2'b00;
      hit_entry = '0;
      e = '0;
      free_way = 2'b00;
      any_free = 1'b0;
      vidx = '0;
      priv_ok = real_mode || (cpl == 2'b00);
      take = priv_ok && (r_q.st == tlb_test_pkg::ST_IDLE);
      set_idx = r_q.ctrl[PAGE_LO +: SET_BITS];
      lru_cur = r_q.lru[set_idx*3 +: 3];
      is_lookup = r_q.ctrl[tlb_test_pkg::CMD_BIT];
      // Tag compare: page, valid, attribute pairs from the control register
      for (int w = NUM_WAYS - 1; w >= 0; w--)
      begin
         e = rd_entries[w*ENTRY_W +: ENTRY_W];
         vidx = {set_idx, 2'(w)};
         if (r_q.valid[vidx] && e[ENTRY_W-1 -: 20] == r_q.ctrl[31:PAGE_LO]
             && attr_ok(r_q.ctrl[10:9], e[22])
             && attr_ok(r_q.ctrl[8:7], e[21])
             && attr_ok(r_q.ctrl[6:5], e[20]))
         begin
            hit = 1'b1;
            hit_way = 2'(w);
            hit_entry = e;
         end
         if (!r_q.valid[vidx])
         begin
            any_free = 1'b1;
            free_way = 2'(w);
         end
      end
      if (mov_rd && take)
      begin
         r_d.rdata = (mov_sel == tlb_test_pkg::SEL_CTRL) ? r_q.ctrl : r_q.data;
      end
      // Reserved bits are dropped on the way in so they read back as zero
      if (mov_wr && take)
      begin
         if (mov_sel == tlb_test_pkg::SEL_CTRL)
         begin
            r_d.ctrl = mov_wdata & tlb_test_pkg::CTRL_WMASK;
            r_d.st = tlb_test_pkg::ST_FETCH;
         end
         else
         begin
            r_d.data = mov_wdata & tlb_test_pkg::DATA_WMASK;
         end
      end
      unique case (r_q.st)
         tlb_test_pkg::ST_IDLE:
         begin
         end
         tlb_test_pkg::ST_FETCH:
         begin
            ram_rd = 1'b1;
            r_d.st = tlb_test_pkg::ST_EXEC;
         end
         tlb_test_pkg::ST_EXEC:
         begin
            r_d.st = tlb_test_pkg::ST_IDLE;
            if (is_lookup)
            begin
               r_d.data[tlb_test_pkg::LRU_LSB +: 3] = lru_cur;
               r_d.data[tlb_test_pkg::HIT_BIT] = hit;
               if (hit)
               begin
                  r_d.data[31:PAGE_LO] = hit_entry[19:0];
                  r_d.data[tlb_test_pkg::WAY_LSB +: 2] = hit_way;
                  r_d.ctrl[tlb_test_pkg::VALID_BIT] = 1'b1;
                  r_d.ctrl[10:9] = {hit_entry[22], !hit_entry[22]};
                  r_d.ctrl[8:7] = {hit_entry[21], !hit_entry[21]};
                  r_d.ctrl[6:5] = {hit_entry[20], !hit_entry[20]};
                  r_d.lru[set_idx*3 +: 3] = plru_touch(lru_cur, hit_way);
               end
            end
            else
            begin
               // Own choice prefers an empty way, then the tree victim
               if (r_q.data[tlb_test_pkg::HIT_BIT])
               begin
                  wr_way = r_q.data[tlb_test_pkg::WAY_LSB +: 2];
               end
               else
               begin
                  wr_way = any_free ? free_way : plru_victim(lru_cur);
               end
               ram_we = 1'b1;
               r_d.valid[{set_idx, wr_way}] = r_q.ctrl[tlb_test_pkg::VALID_BIT];
               r_d.lru[set_idx*3 +: 3] = plru_touch(lru_cur, wr_way);
            end
         end
         default:
         begin
            r_d.st = tlb_test_pkg::ST_IDLE;
         end
      endcase
      // Entry layout: page, dirty, user, write-allowed, physical page
      wr_entry = {r_q.ctrl[31:PAGE_LO], r_q.ctrl[tlb_test_pkg::DIRTY_BIT], r_q.ctrl[tlb_test_pkg::USER_BIT],
                  r_q.ctrl[tlb_test_pkg::RW_BIT], r_q.data[31:PAGE_LO]};
   end

   always_ff @(posedge ref_clk or posedge reset)
   begin
      if (reset)
      begin
         r_q <= '{st: tlb_test_pkg::ST_IDLE, data: tlb_test_pkg::DATA_RESET,
                  ctrl: tlb_test_pkg::CTRL_RESET, rdata: 32'h0000_0000, valid: '0, lru: '0};
      end
      else
      begin
         r_q <= r_d;
      end
   end

   assign mov_rdata = r_q.rdata;
   assign mov_fault = (mov_wr || mov_rd) && !priv_ok;
   assign busy = (r_q.st != tlb_test_pkg::ST_IDLE);
   assign wr_idx = {set_idx, wr_way};

   // ****************************************
   // Checks
   // ****************************************
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (reset);

   property p_priv_block;
      !busy && (mov_wr || mov_rd) && !real_mode && cpl != 2'b00 |=> $stable(r_q.ctrl) && $stable(r_q.data)
         && $stable(r_q.rdata) && !busy;
   endproperty
   a_priv_block: assert property (p_priv_block) else $error("move accepted outside level 0");

   property p_start;
      !busy && mov_wr && mov_sel && priv_ok |=> busy ##1 busy ##1 !busy;
   endproperty
   a_start: assert property (p_start) else $error("control write did not run a two-cycle operation");

   property p_hit_flag;
      r_q.st == tlb_test_pkg::ST_EXEC && is_lookup |=> r_q.data[4] == $past(hit);
   endproperty
   a_hit_flag: assert property (p_hit_flag) else $error("hit flag wrong after lookup");

   property p_hit_way;
      r_q.st == tlb_test_pkg::ST_EXEC && is_lookup && hit |=> r_q.data[3:2] == $past(hit_way)
         && r_q.ctrl[11];
   endproperty
   a_hit_way: assert property (p_hit_way) else $error("hit way not reported");

   property p_lru_prior;
      r_q.st == tlb_test_pkg::ST_EXEC && is_lookup |=> r_q.data[9:7] == $past(lru_cur);
   endproperty
   a_lru_prior: assert property (p_lru_prior) else $error("prior LRU bits not returned");

   property p_write_data;
      r_q.st == tlb_test_pkg::ST_EXEC && !is_lookup |-> ram_we && wr_entry[19:0] == r_q.data[31:12]
         && wr_entry[42:23] == r_q.ctrl[31:12];
   endproperty
   a_write_data: assert property (p_write_data) else $error("write entry content wrong");

   property p_fixed_way;
      r_q.st == tlb_test_pkg::ST_EXEC && !is_lookup && r_q.data[4] |-> wr_way == r_q.data[3:2];
   endproperty
   a_fixed_way: assert property (p_fixed_way) else $error("fixed way not used");

   property p_valid_set;
      r_q.st == tlb_test_pkg::ST_EXEC && !is_lookup |=> r_q.valid[$past(wr_idx)]
         == $past(r_q.ctrl[11]);
   endproperty
   a_valid_set: assert property (p_valid_set) else $error("valid bit not written");

   property p_no_write_on_lookup;
      r_q.st != tlb_test_pkg::ST_EXEC || is_lookup |-> !ram_we;
   endproperty
   a_no_write_on_lookup: assert property (p_no_write_on_lookup) else $error("lookup wrote the array");

   property p_hit_phys;
      r_q.st == tlb_test_pkg::ST_EXEC && is_lookup && hit |=> r_q.data[31:12] == $past(hit_entry[19:0]);
   endproperty
   a_hit_phys: assert property (p_hit_phys) else $error("hit entry page not loaded");

   property p_miss_keeps;
      r_q.st == tlb_test_pkg::ST_EXEC && is_lookup && !hit |=> $stable(r_q.ctrl) && $stable(r_q.data[31:12])
         && $stable(r_q.data[3:2]);
   endproperty
   a_miss_keeps: assert property (p_miss_keeps) else $error("lookup miss changed page, way or control");

   property p_write_attr;
      r_q.st == tlb_test_pkg::ST_EXEC && !is_lookup |-> wr_entry[22:20]
         == {r_q.ctrl[tlb_test_pkg::DIRTY_BIT], r_q.ctrl[tlb_test_pkg::USER_BIT], r_q.ctrl[tlb_test_pkg::RW_BIT]};
   endproperty
   a_write_attr: assert property (p_write_attr) else $error("attribute bits not stored");

   property p_fetch_holds;
      r_q.st == tlb_test_pkg::ST_FETCH |=> $stable(r_q.ctrl) && $stable(r_q.data);
   endproperty
   a_fetch_holds: assert property (p_fetch_holds) else $error("move taken while busy");

   property p_rdata_hold;
      !(mov_rd && priv_ok) |=> $stable(mov_rdata);
   endproperty
   a_rdata_hold: assert property (p_rdata_hold) else $error("read data changed without a read");
endmodule : tlb_test_register_access
`default_nettype wire

// File: verification/tlb_test_register_access_test.sv
// Self-checking bench for the translation buffer test port.
// Assumes the design files are compiled first; moves are driven at the falling edge.
`timescale 1ns/1ps
`default_nettype none
module tlb_test_register_access_test;
   // ****************************************
   // Signals and design
   // ****************************************
   logic ref_clk;
   logic reset;
   logic mov_wr;
   logic mov_rd;
   logic mov_sel;
   logic [31:0] mov_wdata;
   logic [1:0] cpl;
   logic real_mode;
   logic [31:0] mov_rdata;
   logic mov_fault;
   logic busy;
   logic [31:0] v;
   logic fl;
   int n_errors;
   int num_checks;
   typedef struct {
      logic [31:0] wdata;
      logic [31:0] wctrl;
      logic [31:0] lctrl;
      logic [31:0] exp_data;
      logic [31:0] exp_ctrl;
   } row_t;
   // Data write, control write, lookup, then data (LRU masked) and control
   row_t rows [11] = '{
      '{32'habcd_e018, 32'h1234_5cc0, 32'h1234_5001, 32'habcd_e018, 32'h1234_5cc1},
      '{32'habcd_e018, 32'h1234_5cc0, 32'h1234_5201, 32'habcd_e008, 32'h1234_5201},
      '{32'h5555_5000, 32'h0000_d800, 32'h0000_d001, 32'h5555_5010, 32'h0000_daa1},
      '{32'habcd_e018, 32'h1234_5000, 32'h1234_5001, 32'habcd_e008, 32'h1234_5001},
      '{32'h1111_1c13, 32'h1111_181e, 32'h1111_1001, 32'h1111_1010, 32'h1111_1aa1},
      '{32'h3333_301c, 32'h2222_1800, 32'h2222_1001, 32'h3333_301c, 32'h2222_1aa1},
      // Set 3 filled by own choice; the last write must take the tree victim, way 2
      '{32'h4444_4000, 32'h0000_3800, 32'h0000_3001, 32'h4444_4010, 32'h0000_3aa1},
      '{32'h4444_5000, 32'h0000_b800, 32'h0000_b001, 32'h4444_5014, 32'h0000_baa1},
      '{32'h4444_6000, 32'h0001_3800, 32'h0001_3001, 32'h4444_6018, 32'h0001_3aa1},
      '{32'h4444_7000, 32'h0001_b800, 32'h0000_3001, 32'h4444_4010, 32'h0000_3aa1},
      '{32'h4444_8000, 32'h0002_3800, 32'h0002_3001, 32'h4444_8018, 32'h0002_3aa1}
   };

   tlb_test_register_access u_dut (
      .ref_clk(ref_clk),
      .reset(reset),
      .mov_wr(mov_wr),
      .mov_rd(mov_rd),
      .mov_sel(mov_sel),
      .mov_wdata(mov_wdata),
      .cpl(cpl),
      .real_mode(real_mode),
      .mov_rdata(mov_rdata),
      .mov_fault(mov_fault),
      .busy(busy)
   );

   initial
   begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end

   // ****************************************
   // Tasks
   // ****************************************
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp)
      begin
         n_errors++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   // One move; fault sampled while the strobe stands, read data after the edge
   task automatic move(input logic wr, input logic sel, input logic [31:0] d);
      int i;
      @(negedge ref_clk);
      mov_wr = wr;
      mov_rd = !wr;
      mov_sel = sel;
      mov_wdata = d;
      #1 fl = mov_fault;
      @(negedge ref_clk);
      v = mov_rdata;
      mov_wr = 1'b0;
      mov_rd = 1'b0;
      // Bounded wait, a stuck sequencer must not hang the run
      for (i = 0; i < 8 && busy !== 1'b0; i++)
         @(negedge ref_clk);
      chk("busy", 32'h0, {31'h0, busy});
   endtask : move

   task automatic stop_test;
      if (n_errors == 0 && num_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : stop_test

   // ****************************************
   // Watchdog
   // ****************************************
   initial
   begin
      repeat (3000) @(posedge ref_clk);
      n_errors++;
      stop_test();
   end

   // ****************************************
   // Main sequence
   // ****************************************
   initial
   begin
      n_errors = 0;
      num_checks = 0;
      reset = 1'b1;
      mov_wr = 1'b0;
      mov_rd = 1'b0;
      mov_sel = 1'b0;
      mov_wdata = 32'h0;
      cpl = 2'h0;
      real_mode = 1'b0;
      repeat (8) @(posedge ref_clk);
      @(negedge ref_clk);
      reset = 1'b0;
      chk("rdata after reset", 32'h0, mov_rdata);
      move(1'b0, 1'b1, 32'h0);
      chk("ctrl reset", 32'h0, v);
      // Lookup miss on a fresh set; a move while busy must be dropped
      move(1'b1, 1'b0, 32'h0000_4000);
      @(negedge ref_clk);
      mov_wr = 1'b1;
      mov_sel = 1'b1;
      mov_wdata = 32'h0000_4801;
      @(negedge ref_clk);
      chk("busy first", 32'h1, {31'h0, busy});
      mov_sel = 1'b0;
      mov_wdata = 32'h9999_9000;
      @(negedge ref_clk);
      chk("busy second", 32'h1, {31'h0, busy});
      mov_wr = 1'b0;
      @(negedge ref_clk);
      chk("busy done", 32'h0, {31'h0, busy});
      move(1'b0, 1'b0, 32'h0);
      chk("miss data", 32'h0000_4000, v);
      // Privilege: levels 1 to 3 refused, real mode counts as level 0
      for (int p = 1; p < 4; p++)
      begin
         cpl = p[1:0];
         move(1'b1, 1'b0, 32'h7777_7000);
         chk("fault wr", 32'h1, {31'h0, fl});
      end
      real_mode = 1'b1;
      move(1'b1, 1'b0, 32'h0000_f000);
      chk("fault real", 32'h0, {31'h0, fl});
      cpl = 2'h0;
      real_mode = 1'b0;
      move(1'b0, 1'b0, 32'h0);
      chk("priv data", 32'h0000_f000, v);
      cpl = 2'h2;
      move(1'b0, 1'b1, 32'h0);
      chk("fault rd", 32'h1, {31'h0, fl});
      chk("rdata held", 32'h0000_f000, v);
      cpl = 2'h0;
      // Reserved data bits read back as zero
      move(1'b1, 1'b0, 32'hffff_ffff);
      move(1'b0, 1'b0, 32'h0);
      chk("data mask", 32'hffff_f39c, v);
      // Ordinary write then lookup cases
      foreach (rows[i])
      begin
         move(1'b1, 1'b0, rows[i].wdata);
         move(1'b1, 1'b1, rows[i].wctrl);
         move(1'b1, 1'b1, rows[i].lctrl);
         move(1'b0, 1'b0, 32'h0);
         chk("lookup data", rows[i].exp_data, v & 32'hffff_f01c);
         move(1'b0, 1'b1, 32'h0);
         chk("lookup ctrl", rows[i].exp_ctrl, v);
      end
      // Mid-run reset: registers cleared, old array contents must never hit
      @(negedge ref_clk);
      reset = 1'b1;
      @(negedge ref_clk);
      chk("busy in reset", 32'h0, {31'h0, busy});
      chk("rdata in reset", 32'h0, mov_rdata);
      reset = 1'b0;
      move(1'b0, 1'b0, 32'h0);
      chk("data after reset", 32'h0, v);
      move(1'b1, 1'b1, 32'h1111_1001);
      move(1'b0, 1'b0, 32'h0);
      chk("miss after reset", 32'h0, v);
      move(1'b0, 1'b1, 32'h0);
      chk("ctrl after miss", 32'h1111_1001, v);
      stop_test();
   end
endmodule : tlb_test_register_access_test
`default_nettype wire
